//--- common/fcpf_pkg.sv
package fcpf_pkg;

    // Port and storage geometry
    localparam int FCPF_DATA_W = 9;
    localparam int FCPF_DEPTH_DEF = 64;
    localparam int FCPF_DEPTH_MIN = 64;
    localparam int FCPF_DEPTH_MAX = 8192;

    // Flag offsets are two data words each, low word first
    localparam int FCPF_OFF_W = 18;
    localparam int FCPF_CHUNK_LO_POS = 0;
    localparam int FCPF_CHUNK_HI_POS = 9;
    localparam logic [17:0] FCPF_OFF_RST = 18'h00007;

    // Offset access sequence
    localparam int FCPF_IDX_W = 2;
    localparam logic [1:0] FCPF_IDX_AE_LO = 2'h0;
    localparam logic [1:0] FCPF_IDX_AE_HI = 2'h1;
    localparam logic [1:0] FCPF_IDX_AF_LO = 2'h2;
    localparam logic [1:0] FCPF_IDX_AF_HI = 2'h3;
    localparam logic [1:0] FCPF_IDX_RST = 2'h0;

    // Output reset values
    localparam logic [8:0] FCPF_RDATA_RST = 9'h000;
    localparam logic FCPF_EMPTY_N_RST = 1'b0;
    localparam logic FCPF_FULL_N_RST = 1'b1;
    localparam logic FCPF_AEMPTY_N_RST = 1'b0;
    localparam logic FCPF_AFULL_N_RST = 1'b1;
    localparam logic FCPF_OE_N_RST = 1'b1;

    // Pointer sync depth, in flip-flops
    localparam int FCPF_SYNC_STAGES = 2;

endpackage

//--- hw/fcpf_gray_sync.sv
`timescale 1ns/1ns
`default_nettype none

module fcpf_gray_sync #(
    parameter int W = 7
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Pointer in and out
    input wire logic [W-1:0] gray_in,
    output logic [W-1:0] gray_out
);
    import fcpf_pkg::*;

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } fcpf_sync_type;

    fcpf_sync_type s_q;
    fcpf_sync_type s_d;

    // Gray code changes one bit per step, so a torn sample is still valid
    always_comb
    begin
        s_d = s_q;
        s_d.stage1 = gray_in;
        s_d.stage2 = s_q.stage1;
        if (rst)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        s_q <= s_d;
    end

    assign gray_out = s_q.stage2;

endmodule

`default_nettype wire

//--- hw/fcpf_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module fcpf_fifo #(
    parameter int DEPTH = fcpf_pkg::FCPF_DEPTH_DEF
) (
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic master_reset_n,
    // Write port
    input wire logic [fcpf_pkg::FCPF_DATA_W-1:0] write_data,
    input wire logic write_enable_primary_n,
    input wire logic write_enable_or_offset_load,
    // Read port
    input wire logic read_enable_a_n,
    input wire logic read_enable_b_n,
    input wire logic output_enable_n,
    output logic [fcpf_pkg::FCPF_DATA_W-1:0] read_data,
    output logic read_data_oe_n,
    // Flags
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    // Configuration seen at reset
    output logic dual_enable_mode
);
    import fcpf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [FCPF_OFF_W:0] DEPTH_O = (FCPF_OFF_W + 1)'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr_bin;
        logic [PW-1:0] wr_gray;
        logic [PW-1:0] rd_bin;
        logic [PW-1:0] rd_gray;
        logic [FCPF_OFF_W-1:0] ae_off;
        logic [FCPF_OFF_W-1:0] af_off;
        logic [FCPF_IDX_W-1:0] load_wr_idx;
        logic [FCPF_IDX_W-1:0] load_rd_idx;
        logic dual_mode;
        logic [FCPF_DATA_W-1:0] rdata;
        logic oe_n;
        logic empty_n;
        logic full_n;
        logic aempty_n;
        logic afull_n;
    } fcpf_state_type;

    fcpf_state_type s_q;
    fcpf_state_type s_d;

    logic [FCPF_DATA_W-1:0] mem [DEPTH];
    logic [PW-1:0] rd_gray_sync;
    logic [PW-1:0] wr_gray_sync;
    logic res;
    logic offset_load_n;
    logic wr_push;
    logic load_write;
    logic rd_pop;
    logic load_read;
    logic [PW-1:0] wr_count;
    logic [PW-1:0] rd_count;
    logic [FCPF_OFF_W:0] af_sum;
    logic [FCPF_DATA_W-1:0] off_chunk;

    function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    function automatic logic [PW-1:0] to_bin(input logic [PW-1:0] g);
        logic [PW-1:0] b;
        b[PW-1] = g[PW-1];
        for (int i = PW - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        to_bin = b;
    endfunction

    // Each side sees the other pointer only after two flops
    fcpf_gray_sync #(
        .W(PW)
    ) u_rd_to_wr (
        .core_clk(core_clk),
        .rst(res),
        .gray_in(s_q.rd_gray),
        .gray_out(rd_gray_sync)
    );

    fcpf_gray_sync #(
        .W(PW)
    ) u_wr_to_rd (
        .core_clk(core_clk),
        .rst(res),
        .gray_in(s_q.wr_gray),
        .gray_out(wr_gray_sync)
    );

    // Either reset source empties the buffer
    assign res = rst | ~master_reset_n;

    // The dual pin is a load control only in flag mode
    assign offset_load_n = s_q.dual_mode | write_enable_or_offset_load;

    // Same pin level gates both modes: second enable or idle load
    assign wr_push = ~write_enable_primary_n & write_enable_or_offset_load
        & s_q.full_n;
    assign load_write = ~offset_load_n & ~write_enable_primary_n;
    assign load_read = ~offset_load_n & ~read_enable_a_n
        & ~read_enable_b_n;
    assign rd_pop = offset_load_n & ~read_enable_a_n & ~read_enable_b_n
        & s_q.empty_n;

    always_comb
    begin
        unique case (s_q.load_rd_idx)
            FCPF_IDX_AE_LO: off_chunk = s_q.ae_off[FCPF_CHUNK_LO_POS +: 9];
            FCPF_IDX_AE_HI: off_chunk = s_q.ae_off[FCPF_CHUNK_HI_POS +: 9];
            FCPF_IDX_AF_LO: off_chunk = s_q.af_off[FCPF_CHUNK_LO_POS +: 9];
            FCPF_IDX_AF_HI: off_chunk = s_q.af_off[FCPF_CHUNK_HI_POS +: 9];
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        wr_count = '0;
        rd_count = '0;
        af_sum = '0;
        if (res)
        begin
            s_d.wr_bin = '0;
            s_d.wr_gray = '0;
            s_d.rd_bin = '0;
            s_d.rd_gray = '0;
            s_d.ae_off = FCPF_OFF_RST;
            s_d.af_off = FCPF_OFF_RST;
            s_d.load_wr_idx = FCPF_IDX_RST;
            s_d.load_rd_idx = FCPF_IDX_RST;
            // Strap follows the pin for as long as reset is held
            s_d.dual_mode = write_enable_or_offset_load;
            s_d.rdata = FCPF_RDATA_RST;
            s_d.oe_n = FCPF_OE_N_RST;
            s_d.empty_n = FCPF_EMPTY_N_RST;
            s_d.full_n = FCPF_FULL_N_RST;
            s_d.aempty_n = FCPF_AEMPTY_N_RST;
            s_d.afull_n = FCPF_AFULL_N_RST;
        end
        else
        begin
            s_d.oe_n = output_enable_n;
            // Write side
            if (wr_push)
            begin
                s_d.wr_bin = s_q.wr_bin + PW'(1);
                s_d.wr_gray = to_gray(s_d.wr_bin);
            end
            if (load_write)
            begin
                unique case (s_q.load_wr_idx)
                    FCPF_IDX_AE_LO:
                        s_d.ae_off[FCPF_CHUNK_LO_POS +: 9] = write_data;
                    FCPF_IDX_AE_HI:
                        s_d.ae_off[FCPF_CHUNK_HI_POS +: 9] = write_data;
                    FCPF_IDX_AF_LO:
                        s_d.af_off[FCPF_CHUNK_LO_POS +: 9] = write_data;
                    FCPF_IDX_AF_HI:
                        s_d.af_off[FCPF_CHUNK_HI_POS +: 9] = write_data;
                endcase
                s_d.load_wr_idx = s_q.load_wr_idx + FCPF_IDX_W'(1);
            end
            // Read side
            if (rd_pop)
            begin
                s_d.rdata = mem[s_q.rd_bin[AW-1:0]];
                s_d.rd_bin = s_q.rd_bin + PW'(1);
                s_d.rd_gray = to_gray(s_d.rd_bin);
            end
            else if (load_read)
            begin
                s_d.rdata = off_chunk;
                s_d.load_rd_idx = s_q.load_rd_idx + FCPF_IDX_W'(1);
            end
            // Write-side flags see a stale read pointer, so full is
            // pessimistic: safe, at the cost of a few cycles of headroom
            wr_count = s_d.wr_bin - to_bin(rd_gray_sync);
            af_sum = (FCPF_OFF_W + 1)'(wr_count)
                + {1'b0, s_d.af_off};
            s_d.full_n = wr_count != DEPTH_P;
            s_d.afull_n = af_sum < DEPTH_O;
            // Read-side flags likewise lag incoming writes
            rd_count = to_bin(wr_gray_sync) - s_d.rd_bin;
            s_d.empty_n = rd_count != '0;
            s_d.aempty_n = FCPF_OFF_W'(rd_count) > s_d.ae_off;
        end
    end

    // Flags are registered, so each new value stands a full cycle
    always_ff @(posedge core_clk)
    begin
        s_q <= s_d;
    end

    // Storage has no reset; only pointers define what is valid
    always_ff @(posedge core_clk)
    begin
        if (wr_push && !res)
        begin
            mem[s_q.wr_bin[AW-1:0]] <= write_data;
        end
    end

    assign read_data = s_q.rdata;
    assign read_data_oe_n = s_q.oe_n;
    assign empty_flag_n = s_q.empty_n;
    assign full_flag_n = s_q.full_n;
    assign almost_empty_flag_n = s_q.aempty_n;
    assign almost_full_flag_n = s_q.afull_n;
    assign dual_enable_mode = s_q.dual_mode;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (res);

    sequence idle3_s;
        (!wr_push && !rd_pop)[*3];
    endsequence

    sequence drained_s;
        (s_q.wr_bin == s_q.rd_bin) ##0 idle3_s;
    endsequence

    sequence filled_s;
        ((s_q.wr_bin - s_q.rd_bin) == DEPTH_P) ##0 idle3_s;
    endsequence

    full_blocks_a: assert property (
        (!full_flag_n && !write_enable_primary_n) |=> $stable(s_q.wr_bin))
        else $error("write accepted while full");

    occupancy_cap_a: assert property (
        (s_q.wr_bin - s_q.rd_bin) <= DEPTH_P)
        else $error("buffer occupancy above depth");

    empty_blocks_a: assert property (
        !empty_flag_n |=> $stable(s_q.rd_bin))
        else $error("word removed while empty");

    push_step_a: assert property (
        wr_push |=> s_q.wr_bin == $past(s_q.wr_bin) + PW'(1))
        else $error("write pointer did not advance by one");

    strap_capture_a: assert property (
        @(posedge core_clk) $fell(res)
        |-> s_q.dual_mode == $past(write_enable_or_offset_load))
        else $error("mode strap not taken from reset level");

    reset_empty_a: assert property (
        @(posedge core_clk) disable iff (1'b0)
        res |=> (!empty_flag_n && s_q.wr_bin == s_q.rd_bin))
        else $error("reset did not empty the buffer");

    load_store_a: assert property (
        (load_write && s_q.load_wr_idx == FCPF_IDX_AE_LO)
        |=> (s_q.ae_off[8:0] == $past(write_data) && $stable(s_q.wr_bin)))
        else $error("offset load failed or wrote buffer");

    load_readback_a: assert property (
        (load_read && s_q.load_rd_idx == FCPF_IDX_AF_LO)
        |=> read_data == $past(s_q.af_off[8:0]))
        else $error("offset readback wrong");

    empty_settle_a: assert property (
        drained_s |=> !empty_flag_n)
        else $error("empty flag not low after drain");

    full_settle_a: assert property (
        filled_s |=> !full_flag_n)
        else $error("full flag not low at capacity");

    oe_follow_a: assert property (
        ##1 (read_data_oe_n == $past(output_enable_n)))
        else $error("output enable not followed");

endmodule

`default_nettype wire

//--- tb/fcpf_bus_model.sv
`timescale 1ns/1ns
`default_nettype none

module fcpf_bus_model
    import fcpf_pkg::*;
(
    // Device side of the data pins
    input wire logic [FCPF_DATA_W-1:0] read_data,
    input wire logic read_data_oe_n,
    // Level seen on the shared bus
    output logic [FCPF_DATA_W-1:0] data_wire
);
    logic [FCPF_DATA_W-1:0] last_q = '0;

    // No pull on this bus, so a released wire shows the inverse of its
    // last level; a stale value must never pass for a driven one
    always @*
    begin
        if (!read_data_oe_n)
            last_q = read_data;
        data_wire = read_data_oe_n ? ~last_q : read_data;
    end
endmodule

`default_nettype wire

//--- tb/test_dual_clock_fifo_prog_flags.sv
`timescale 1ns/1ns
`default_nettype none

module test_dual_clock_fifo_prog_flags;
    import fcpf_pkg::*;

    localparam int DEPTH = 64;
    logic core_clk, rst, mr_n, we_pri_n, we_dual, ren_a_n, ren_b_n, oe_n;
    logic [FCPF_DATA_W-1:0] wdata, read_data, data_wire;
    logic read_data_oe_n, empty_n, full_n, ae_n, af_n, dual;
    logic [FCPF_DATA_W-1:0] exp_q[$];
    logic [FCPF_DATA_W-1:0] load_v[4];
    logic [FCPF_DATA_W-1:0] last_w = '0;
    int err_count = 0;
    int cmp_count = 0;

    fcpf_fifo #(.DEPTH(DEPTH)) dut (
        .core_clk(core_clk), .rst(rst), .master_reset_n(mr_n),
        .write_data(wdata), .write_enable_primary_n(we_pri_n),
        .write_enable_or_offset_load(we_dual),
        .read_enable_a_n(ren_a_n), .read_enable_b_n(ren_b_n),
        .output_enable_n(oe_n), .read_data(read_data),
        .read_data_oe_n(read_data_oe_n), .empty_flag_n(empty_n),
        .full_flag_n(full_n), .almost_empty_flag_n(ae_n),
        .almost_full_flag_n(af_n), .dual_enable_mode(dual)
    );

    fcpf_bus_model bus (
        .read_data(read_data), .read_data_oe_n(read_data_oe_n),
        .data_wire(data_wire)
    );

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    task give_verdict;
        if (err_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [FCPF_DATA_W-1:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task chkf(input logic got, input logic exp);
        chk({8'h00, got}, {8'h00, exp});
    endtask

    task settle;
        repeat (4) @(negedge core_clk);
    endtask

    // Strap is sampled while reset is held, so it is set up front
    task do_reset(input logic strap, input logic by_pin);
        @(negedge core_clk);
        rst = !by_pin;
        mr_n = !by_pin;
        we_dual = strap;
        we_pri_n = 1'b1;
        ren_a_n = 1'b1;
        ren_b_n = 1'b1;
        repeat (3) @(negedge core_clk);
        chkf(empty_n, 1'b0);
        chkf(full_n, 1'b1);
        chkf(ae_n, 1'b0);
        chkf(af_n, 1'b1);
        chkf(read_data_oe_n, 1'b1);
        chkf(dual, strap);
        rst = 1'b0;
        mr_n = 1'b1;
        we_dual = 1'b1;
        exp_q.delete();
    endtask

    // Random traffic; a request counts only if its flag allowed it
    task run(input int n, input int wp, input int rp);
        logic took;
        took = 1'b0;
        for (int i = 0; i <= n; i++)
        begin
            @(negedge core_clk);
            if (took)
            begin
                // A pop the model did not expect can never match
                if (exp_q.size() > 0)
                    last_w = exp_q.pop_front();
                else
                    last_w = ~read_data;
                chk(read_data, last_w);
            end
            we_pri_n = 1'b1;
            ren_a_n = 1'b1;
            ren_b_n = 1'b1;
            took = 1'b0;
            if (i < n)
            begin
                wdata = FCPF_DATA_W'($urandom);
                we_pri_n = $urandom_range(99) >= wp;
                ren_a_n = $urandom_range(99) >= rp;
                ren_b_n = $urandom_range(99) >= rp;
                if (!we_pri_n && full_n === 1'b1)
                    exp_q.push_back(wdata);
                took = !ren_a_n && !ren_b_n && empty_n === 1'b1;
            end
        end
    endtask

    initial
    begin
        rst = 1'b1;
        mr_n = 1'b1;
        we_pri_n = 1'b1;
        we_dual = 1'b1;
        ren_a_n = 1'b1;
        ren_b_n = 1'b1;
        oe_n = 1'b1;
        wdata = '0;
        void'($urandom(41373));
        do_reset(1'b1, 1'b0);
        @(negedge core_clk);
        we_pri_n = 1'b0;
        we_dual = 1'b0;
        repeat (3) @(negedge core_clk);
        we_pri_n = 1'b1;
        we_dual = 1'b1;
        settle;
        chkf(empty_n, 1'b0);
        run(DEPTH - 8, 100, 0);
        settle;
        chkf(af_n, 1'b1);
        chkf(empty_n, 1'b1);
        run(1, 100, 0);
        settle;
        chkf(af_n, 1'b0);
        run(6, 100, 0);
        settle;
        chkf(full_n, 1'b1);
        run(3, 100, 0);
        settle;
        chkf(full_n, 1'b0);
        run(DEPTH - 8, 0, 100);
        settle;
        chkf(ae_n, 1'b1);
        run(1, 0, 100);
        settle;
        chkf(ae_n, 1'b0);
        run(9, 0, 100);
        chk(read_data, last_w);
        chkf(empty_n, 1'b0);
        chk({8'h00, exp_q.size() == 0}, 9'h001);
        run(300, 60, 50);
        run(90, 0, 100);
        settle;
        chkf(empty_n, 1'b0);
        do_reset(1'b0, 1'b1);
        load_v = '{9'h003, 9'h000, 9'h005, 9'h000};
        for (int i = 0; i < 5; i++)
        begin
            @(negedge core_clk);
            we_dual = i < 4 ? 1'b0 : 1'b1;
            we_pri_n = i < 4 ? 1'b0 : 1'b1;
            wdata = i < 4 ? load_v[i] : 9'h1FF;
        end
        for (int i = 0; i < 5; i++)
        begin
            @(negedge core_clk);
            if (i > 0)
                chk(read_data, load_v[i - 1]);
            we_dual = i == 4;
            ren_a_n = i == 4;
            ren_b_n = i == 4;
        end
        run(3, 100, 0);
        settle;
        chkf(ae_n, 1'b0);
        run(1, 100, 0);
        settle;
        chkf(ae_n, 1'b1);
        run(DEPTH - 10, 100, 0);
        settle;
        chkf(af_n, 1'b1);
        run(1, 100, 0);
        settle;
        chkf(af_n, 1'b0);
        oe_n = 1'b0;
        repeat (2) @(negedge core_clk);
        chkf(read_data_oe_n, 1'b0);
        chk(data_wire, read_data);
        oe_n = 1'b1;
        repeat (2) @(negedge core_clk);
        chkf(read_data_oe_n, 1'b1);
        chk(data_wire, ~read_data);
        run(90, 0, 100);
        settle;
        chkf(empty_n, 1'b0);
        give_verdict;
    end
endmodule

`default_nettype wire
